// ---- hw/bma_pkg.sv ----
package bma_pkg;
    // timing
    localparam int              CLK_PERIOD_NS  = 40;
    localparam longint          CLK_HZ         = 64'd1000000000 / CLK_PERIOD_NS;
    // 44.1 kHz frames, 64 bit cells per frame, two halves per cell
    localparam longint          HALF_CELL_HZ   = 64'd5644800;
    localparam int              NCO_W          = 24;
    localparam logic [NCO_W-1:0] NCO_INC       = NCO_W'((HALF_CELL_HZ << NCO_W) / CLK_HZ);

    // subframe layout
    localparam logic [5:0]      HALF_FIRST     = 6'h00;
    localparam logic [5:0]      HALF_LAST      = 6'h3f;
    localparam logic [5:0]      PRE_HALVES     = 6'h08;
    localparam int              BIT_FLAG       = 4;
    localparam int              AUX_MSB        = 7;
    localparam int              AUX_ZERO_LSB   = 5;
    localparam int              SAMP_ZERO_LSB  = 8;
    localparam int              SAMP_ZERO_MSB  = 11;
    localparam int              SAMP_LSB       = 12;
    localparam int              SAMP_MSB       = 27;
    localparam int              BIT_VALID      = 28;
    localparam int              BIT_USER       = 29;
    localparam int              BIT_CS         = 30;
    localparam int              BIT_PAR        = 31;
    localparam int              PAR_LSB        = 4;

    // preambles as absolute levels after a low line, first half leftmost
    localparam logic [7:0]      PRE_B          = 8'he8;
    localparam logic [7:0]      PRE_M          = 8'he2;
    localparam logic [7:0]      PRE_W          = 8'he4;

    // channel-status word
    localparam logic [7:0]      CS_LAST        = 8'hbf;
    localparam logic [7:0]      CS_FIRST       = 8'h00;
    localparam logic [7:0]      CS_CTL_LSB     = 8'h01;
    localparam logic [7:0]      CS_CTL_MSB     = 8'h04;
    localparam logic [7:0]      CS_CAT_BIT     = 8'h08;
    localparam logic [7:0]      CS_ACC_LSB     = 8'h1c;
    localparam logic [7:0]      CS_ACC_MSB     = 8'h1d;
    localparam logic [7:0]      CS_ZERO_FROM   = 8'h1e;

    // register indices; byte address is four times the index
    localparam logic [5:0]      IDX_CTRL       = 6'h0a;
    localparam logic [5:0]      IDX_CTRL2      = 6'h0b;
    localparam logic [5:0]      IDX_STAT       = 6'h0c;
    localparam logic [7:0]      CTRL_RST       = 8'h00;
    localparam logic [7:0]      CTRL2_RST      = 8'h00;
    localparam int              CTRL_MODE_MSB  = 1;
    localparam int              CTRL_FLAG_BIT  = 3;
    localparam int              CTRL2_ACC_MSB  = 5;
    localparam int              CTRL2_ACC_LSB  = 4;
    localparam int              STAT_RIGHT_BIT = 8;
    localparam int              STAT_EN_BIT    = 9;

    typedef enum logic [1:0] {
        BMA_MODE_OFF  = 2'h0,
        BMA_MODE_ON   = 2'h1,
        BMA_MODE_MUTE = 2'h2,
        BMA_MODE_RSVD = 2'h3
    } bma_mode_t;
endpackage

// ---- hw/bma_cs_gen.sv ----
`timescale 1ns/1ps
module bma_cs_gen (
    input  wire logic [7:0] cs_index,
    input  wire logic [7:0] ctrl_two,
    output logic            cs_bit
);
    import bma_pkg::*;

    always_comb begin
        cs_bit = 1'b0;
        if (cs_index >= CS_CTL_LSB && cs_index <= CS_CTL_MSB) begin
            cs_bit = ctrl_two[2'(CS_CTL_MSB - cs_index)];
        end else if (cs_index == CS_CAT_BIT) begin
            cs_bit = 1'b1;
        end else if (cs_index == CS_ACC_LSB) begin
            cs_bit = ctrl_two[CTRL2_ACC_MSB];
        end else if (cs_index == CS_ACC_MSB) begin
            cs_bit = ctrl_two[CTRL2_ACC_LSB];
        end
    end
endmodule // bma_cs_gen

// ---- hw/bma_bmc_enc.sv ----
`timescale 1ns/1ps
module bma_bmc_enc (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        half_tick,
    input  wire logic        enable,
    input  wire logic [5:0]  half_index,
    input  wire logic [31:0] word,
    input  wire logic [7:0]  preamble,
    output logic             line_level
);
    import bma_pkg::*;

    typedef struct packed {
        logic level;
        logic ref_level;
    } bma_enc_st_t;

    bma_enc_st_t st_q;
    bma_enc_st_t st_d;
    logic        cell_bit;

    assign cell_bit   = word[half_index[5:1]];
    assign line_level = st_q.level;

    always_comb begin
        st_d = st_q;
        if (!enable) begin
            st_d = '0;
        end else if (half_tick) begin
            if (half_index == HALF_FIRST) begin
                // preamble is relative to the level the last subframe left
                st_d.ref_level = st_q.level;
                st_d.level     = st_q.level ^ preamble[7];
            end else if (half_index < PRE_HALVES) begin
                st_d.level = st_q.ref_level ^ preamble[3'(7 - half_index)];
            end else if (!half_index[0]) begin
                st_d.level = ~st_q.level;
            end else if (cell_bit) begin
                st_d.level = ~st_q.level;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    chk_cell_boundary: assert property (@(posedge clk_sys) disable iff (!rstn)
        half_tick && enable && $past(enable) && half_index >= PRE_HALVES && !half_index[0]
        |=> line_level != $past(line_level))
        else $error("no transition at bit cell boundary");
    chk_zero_no_mid: assert property (@(posedge clk_sys) disable iff (!rstn)
        half_tick && enable && half_index >= PRE_HALVES && half_index[0] && !cell_bit
        |=> $stable(line_level))
        else $error("mid-cell transition on a zero");
    chk_one_mid: assert property (@(posedge clk_sys) disable iff (!rstn)
        half_tick && enable && half_index >= PRE_HALVES && half_index[0] && cell_bit
        |=> line_level != $past(line_level))
        else $error("missing mid-cell transition on a one");
    chk_pre_lead_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
        half_tick && enable && half_index == HALF_FIRST
        |=> line_level != $past(line_level))
        else $error("preamble does not start with a transition");
endmodule // bma_bmc_enc

// ---- hw/bma_tx.sv ----
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module bma_tx (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] pcm_left,
    input  wire logic [15:0] pcm_right,
    input  wire logic        pcm_err_left,
    input  wire logic        pcm_err_right,
    input  wire logic        corrector_flag_stream,
    input  wire logic        user_bit_in,
    output logic             pcm_take,
    output logic             user_take,
    output logic             biphase_audio_out_pin
);
    import bma_pkg::*;

    typedef struct packed {
        logic [7:0]       ctrl;
        logic [7:0]       ctrl2;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic [NCO_W-1:0] acc;
        logic             tick;
        logic [5:0]       half;
        logic             right;
        logic [7:0]       cs_idx;
        logic [31:0]      word;
        logic [7:0]       pre;
        logic             en;
        logic [15:0]      samp_r;
        logic             err_r;
        logic             pcm_take;
        logic             user_take;
    } bma_tx_st_t;

    // first half-cell tick wraps to a left block-start subframe
    localparam bma_tx_st_t TX_RST = '{
        ctrl:   CTRL_RST,
        ctrl2:  CTRL2_RST,
        half:   HALF_LAST,
        right:  1'b1,
        cs_idx: CS_LAST,
        pre:    PRE_B,
        default: '0
    };

    bma_tx_st_t     q;
    bma_tx_st_t     d;
    logic [NCO_W:0] nco_sum;
    logic [7:0]     nxt_cs;
    logic           cs_bit;
    logic           loaded;
    bma_mode_t      mode;

    assign mode    = bma_mode_t'(q.ctrl[CTRL_MODE_MSB:0]);
    assign nco_sum = {1'b0, q.acc} + {1'b0, NCO_INC};
    // index advances once per pair, on the left subframe
    assign nxt_cs  = !q.right ? q.cs_idx : ((q.cs_idx == CS_LAST) ? CS_FIRST : q.cs_idx + 8'h01);
    assign loaded  = q.tick && (q.half == HALF_FIRST);

    bma_cs_gen u_cs (
        .cs_index (nxt_cs),
        .ctrl_two (q.ctrl2),
        .cs_bit   (cs_bit)
    );

    always_comb begin
        logic [15:0] samp;
        logic        err;
        logic [31:0] w;
        samp = '0;
        err  = 1'b0;
        w    = '0;
        d    = q;
        d.tick      = 1'b0;
        d.pcm_take  = 1'b0;
        d.user_take = 1'b0;

        // one wait state: pready rises in the second access cycle
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = '0;
            case (paddr[7:2])
                IDX_CTRL: begin
                    if (!pwrite) begin
                        d.prdata[7:0] = q.ctrl;
                    end
                end
                IDX_CTRL2: begin
                    if (!pwrite) begin
                        d.prdata[7:0] = q.ctrl2;
                    end
                end
                IDX_STAT: begin
                    d.prdata[7:0]           = q.cs_idx;
                    d.prdata[STAT_RIGHT_BIT] = q.right;
                    d.prdata[STAT_EN_BIT]    = q.en;
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
        end
        // write lands at the edge where the master samples pready, not earlier
        if (psel && penable && pwrite && q.pready) begin
            if (paddr[7:2] == IDX_CTRL) begin
                d.ctrl = pwdata[7:0];
            end else if (paddr[7:2] == IDX_CTRL2) begin
                d.ctrl2 = pwdata[7:0];
            end
        end

        // fractional divider: 25 MHz is no integer multiple of the half-cell rate
        d.acc = nco_sum[NCO_W-1:0];
        if (nco_sum[NCO_W]) begin
            d.tick = 1'b1;
            d.half = q.half + 6'h01;
            if (q.half == HALF_LAST) begin
                d.right  = ~q.right;
                d.cs_idx = nxt_cs;
                if (q.right) begin
                    d.pre      = (nxt_cs == CS_FIRST) ? PRE_B : PRE_M;
                    samp       = pcm_left;
                    err        = pcm_err_left;
                    // right sample taken with the left keeps the pair together
                    d.samp_r   = pcm_right;
                    d.err_r    = pcm_err_right;
                    d.pcm_take = 1'b1;
                end else begin
                    d.pre = PRE_W;
                    samp  = q.samp_r;
                    err   = q.err_r;
                end
                if (mode == BMA_MODE_MUTE) begin
                    samp = '0;
                end
                w[BIT_FLAG]             = q.ctrl[CTRL_FLAG_BIT] & corrector_flag_stream;
                w[SAMP_MSB:SAMP_LSB]    = samp;
                w[BIT_VALID]            = err;
                w[BIT_USER]             = user_bit_in;
                w[BIT_CS]               = cs_bit;
                w[BIT_PAR]              = ^w[BIT_CS:PAR_LSB];
                d.word      = w;
                d.user_take = 1'b1;
                // mode switches only between subframes, never mid-word
                d.en        = (mode == BMA_MODE_ON) || (mode == BMA_MODE_MUTE);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= TX_RST;
        end else begin
            q <= d;
        end
    end

    bma_bmc_enc u_enc (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .half_tick  (q.tick),
        .enable     (q.en),
        .half_index (q.half),
        .word       (q.word),
        .preamble   (q.pre),
        .line_level (biphase_audio_out_pin)
    );

    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign pcm_take  = q.pcm_take;
    assign user_take = q.user_take;

    chk_pre_block: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && !q.right && q.cs_idx == CS_FIRST |-> q.pre == PRE_B)
        else $error("block start without B preamble");
    chk_pre_left: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && !q.right && q.cs_idx != CS_FIRST |-> q.pre == PRE_M)
        else $error("left subframe without M preamble");
    chk_pre_right: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && q.right |-> q.pre == PRE_W)
        else $error("right subframe without W preamble");
    chk_side_alternate: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded |-> q.right != $past(q.right))
        else $error("channels did not alternate");
    chk_side_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
        !loaded && !$past(loaded) ##1 !loaded |-> $stable(q.right))
        else $error("channel changed inside a subframe");
    chk_parity_even: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded |-> !(^q.word[BIT_PAR:PAR_LSB]))
        else $error("odd parity over bits 4 to 31");
    chk_aux_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded |-> q.word[AUX_MSB:AUX_ZERO_LSB] == '0 && q.word[SAMP_ZERO_MSB:SAMP_ZERO_LSB] == '0)
        else $error("unused auxiliary or sample bits not zero");
    chk_flag_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && !$past(q.ctrl[CTRL_FLAG_BIT]) |-> !q.word[BIT_FLAG])
        else $error("flag bit set while flag mode off");
    chk_left_sample: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && !q.right && $past(mode) == BMA_MODE_ON
        |-> q.word[SAMP_MSB:SAMP_LSB] == $past(pcm_left))
        else $error("left sample not placed in bits 12 to 27");
    chk_valid_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && !q.right |-> q.word[BIT_VALID] == $past(pcm_err_left))
        else $error("validity does not follow error flag");
    chk_cs_pair: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && q.right |-> $stable(q.cs_idx))
        else $error("status index moved inside a pair");
    chk_cs_range: assert property (@(posedge clk_sys) disable iff (!rstn)
        q.cs_idx <= CS_LAST)
        else $error("status index beyond 191");
    chk_cs_category: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && q.cs_idx == CS_CAT_BIT |-> q.word[BIT_CS])
        else $error("category bit 8 not set");
    chk_cs_tail_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded && q.cs_idx >= CS_ZERO_FROM |-> !q.word[BIT_CS])
        else $error("status bits 30 to 191 not zero");
    chk_apb_answer: assert property (@(posedge clk_sys) disable iff (!rstn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("register access not answered in one cycle");

    cov_block_start: cover property (@(posedge clk_sys) disable iff (!rstn)
        loaded && q.pre == PRE_B && q.en);
    cov_right_sub: cover property (@(posedge clk_sys) disable iff (!rstn)
        loaded && q.right && q.en);
    cov_flag_mode: cover property (@(posedge clk_sys) disable iff (!rstn)
        loaded && q.word[BIT_FLAG]);
    cov_bad_addr: cover property (@(posedge clk_sys) disable iff (!rstn)
        pready && pslverr);
endmodule // bma_tx

// ---- dv/bma_rx_model.sv ----
`timescale 1ns/1ps
module bma_rx_model (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        line,
    output logic             sf_valid,
    output logic [1:0]       sf_kind,
    output logic [31:0]      sf_word,
    output logic             code_err
);
    logic        last_q;
    logic [7:0]  run_q;
    logic [3:0]  pre_q;
    logic [1:0]  kind_q;
    logic [4:0]  nbit_q;
    logic        half_q;
    logic        sync_q;
    logic [31:0] acc_q;
    logic [1:0]  n;
    logic        got;

    // a half cell is 4 or 5 clocks, so runs of 1, 2 and 3 halves separate cleanly
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            last_q   <= 1'b0;
            run_q    <= 8'h00;
            pre_q    <= 4'h0;
            nbit_q   <= 5'h00;
            half_q   <= 1'b0;
            sync_q   <= 1'b0;
            sf_valid <= 1'b0;
            code_err <= 1'b0;
        end else begin
            sf_valid <= 1'b0;
            code_err <= 1'b0;
            last_q   <= line;
            run_q    <= (line != last_q) ? 8'h01 : run_q + 8'(run_q != 8'hff);
            n = (run_q < 8'h07) ? 2'h1 : ((run_q < 8'h0c) ? 2'h2 : 2'h3);
            got = 1'b0;
            // a quiet line drops framing; the next long run restarts it
            if (line != last_q && run_q > 8'h14) begin
                sync_q <= 1'b0;
                pre_q  <= 4'h0;
            end else if (line != last_q && n == 2'h3 && pre_q == 4'h0) begin
                code_err <= sync_q & (nbit_q != 5'h00);
                sync_q   <= 1'b1;
                pre_q    <= 4'h3;
                nbit_q   <= 5'h00;
                half_q   <= 1'b0;
            end else if (line != last_q && sync_q && pre_q != 4'h0) begin
                if (pre_q == 4'h3) kind_q <= (n == 2'h1) ? 2'h0 : ((n == 2'h3) ? 2'h1 : 2'h2);
                pre_q    <= (pre_q + 4'(n) < 4'h8) ? pre_q + 4'(n) : 4'h0;
                code_err <= (pre_q + 4'(n) > 4'h8);
            end else if (line != last_q && sync_q) begin
                got = 1'b1;
            end
            if (got && n == 2'h1 && !half_q) begin
                half_q <= 1'b1;
            end else if (got) begin
                code_err <= (n == 2'h2) & half_q;
                half_q   <= 1'b0;
                acc_q    <= {n == 2'h1, acc_q[31:1]};
                nbit_q   <= (nbit_q == 5'd27) ? 5'h00 : nbit_q + 5'h01;
                sf_valid <= (nbit_q == 5'd27);
                sf_kind  <= kind_q;
                sf_word  <= {n == 2'h1, acc_q[31:5], 4'h0};
            end
        end
    end
endmodule // bma_rx_model

// ---- dv/biphase_mark_audio_output_bench.sv ----
`timescale 1ns/1ps
module biphase_mark_audio_output_bench;
    import bma_pkg::*;
    typedef struct {
        int          t;
        logic [1:0]  k;
        logic [31:0] w;
    } bma_exp_t;
    localparam logic [7:0] MODES [4] = '{8'h01, 8'h09, 8'h0a, 8'h02};
    logic        clk_sys;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] pcm_left;
    logic [15:0] pcm_right;
    logic        pcm_err_left;
    logic        pcm_err_right;
    logic        corrector_flag_stream;
    logic        user_bit_in;
    logic        pcm_take;
    logic        user_take;
    logic        biphase_audio_out_pin;
    logic        sf_valid;
    logic [1:0]  sf_kind;
    logic [31:0] sf_word;
    logic        code_err;
    integer      seed;
    int          errors;
    int          checks_done;
    int          cyc;
    int          skip;
    int          frames;
    int          nf;
    logic [7:0]  cidx;
    logic [7:0]  ctrl;
    logic [7:0]  ctrl2;
    logic [7:0]  v;
    logic [15:0] cap_r;
    logic        cap_er;
    logic [31:0] rd;
    logic        er;
    bma_exp_t    q[$];
    bma_exp_t    e;

    bma_tx i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pcm_left(pcm_left), .pcm_right(pcm_right), .pcm_err_left(pcm_err_left),
        .pcm_err_right(pcm_err_right), .corrector_flag_stream(corrector_flag_stream),
        .user_bit_in(user_bit_in), .pcm_take(pcm_take), .user_take(user_take),
        .biphase_audio_out_pin(biphase_audio_out_pin));
    bma_rx_model i_rx (.clk_sys(clk_sys), .rstn(rstn), .line(biphase_audio_out_pin),
        .sf_valid(sf_valid), .sf_kind(sf_kind), .sf_word(sf_word), .code_err(code_err));

    function automatic logic cs_exp(input logic [7:0] i, input logic [7:0] c);
        if (i == CS_CAT_BIT) return 1'b1;
        if (i >= CS_CTL_LSB && i <= CS_CTL_MSB) return c[4 - i];
        if (i == CS_ACC_LSB) return c[5];
        if (i == CS_ACC_MSB) return c[4];
        return 1'b0;
    endfunction

    function automatic logic [31:0] exp_word(input logic [15:0] s, input logic er_in, input logic u,
                                             input logic f, input logic [7:0] c, input logic cs);
        logic [31:0] w;
        w = 32'h0;
        w[4] = c[3] & f;
        w[27:12] = (c[1:0] == 2'h2) ? 16'h0 : s;
        w[28] = er_in;
        w[29] = u;
        w[30] = cs;
        w[31] = ^w[30:4];
        return w;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic summarize;
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // entered just after a rising edge; leaves one idle edge so it may be called again at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic x);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        x = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wait_take(input int k);
        repeat (k) begin
            @(posedge clk_sys);
            while (pcm_take !== 1'b1) @(posedge clk_sys);
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rstn === 1'b1) begin
            if (code_err === 1'b1) check(32'h1, 32'h0);
            if (pcm_take === 1'b1) begin
                cidx = (cidx == CS_LAST) ? CS_FIRST : cidx + 8'h01;
                cap_r = pcm_right;
                cap_er = pcm_err_right;
                e.w = exp_word(pcm_left, pcm_err_left, user_bit_in, corrector_flag_stream, ctrl, cs_exp(cidx, ctrl2));
                e.k = (cidx == CS_FIRST) ? 2'h0 : 2'h1;
                pcm_left <= 16'($random(seed));
                pcm_right <= 16'($random(seed));
                pcm_err_left <= 1'($random(seed));
                pcm_err_right <= 1'($random(seed));
            end else if (user_take === 1'b1) begin
                e.w = exp_word(cap_r, cap_er, user_bit_in, corrector_flag_stream, ctrl, cs_exp(cidx, ctrl2));
                e.k = 2'h2;
            end
            if (user_take === 1'b1) begin
                e.t = cyc;
                q.push_back(e);
                user_bit_in <= 1'($random(seed));
                corrector_flag_stream <= 1'($random(seed));
            end
            if (sf_valid === 1'b1) begin
                frames++;
                while (q.size() > 0 && cyc - q[0].t > 296) void'(q.pop_front());
                if (q.size() == 0 || cyc - q[0].t < 272) begin
                    check(32'h1, 32'h0);
                end else begin
                    e = q.pop_front();
                    if (skip > 0) skip--;
                    else check(sf_word, e.w);
                    if (skip == 0) check({30'h0, sf_kind}, {30'h0, e.k});
                end
            end
        end
    end

    initial begin
        repeat (95000) @(posedge clk_sys);
        errors++;
        summarize();
    end

    initial begin
        seed = 32'hf27d;
        errors = 0;
        checks_done = 0;
        cyc = 0;
        skip = 0;
        frames = 0;
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pcm_left, pcm_right, pcm_err_left, pcm_err_right} = '0;
        {corrector_flag_stream, user_bit_in} = 2'h0;
        ctrl = MODES[0];
        ctrl2 = CTRL2_RST;
        cidx = CS_LAST;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        // mode write lands before the first subframe so the block start goes out
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, {IDX_CTRL, 2'h0}, {24'h0, MODES[p]}, rd, er);
            ctrl = MODES[p];
            if (p == 0) apb(1'b0, {IDX_CTRL2, 2'h0}, 32'h0, rd, er);
            if (p == 0) check(rd, {24'h0, CTRL2_RST});
            v = 8'($random(seed));
            apb(1'b1, {IDX_CTRL2, 2'h0}, {24'h0, v}, rd, er);
            ctrl2 = v;
            skip = (p == 0) ? 0 : 2;
            wait_take(1);
            apb(1'b0, {IDX_STAT, 2'h0}, 32'h0, rd, er);
            check({23'h0, rd[8:0]}, {24'h0, cidx});
            apb(1'b0, {IDX_CTRL, 2'h0}, 32'h0, rd, er);
            check(rd, {24'h0, MODES[p]});
            wait_take(33);
        end
        apb(1'b0, 8'hfc, 32'h0, rd, er);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, {IDX_STAT, 2'h0}, 32'hff, rd, er);
        check({31'h0, er}, 32'h0);
        apb(1'b1, {IDX_CTRL, 2'h0}, 32'h3, rd, er);
        wait_take(2);
        nf = frames;
        wait_take(2);
        check(32'(frames), 32'(nf));
        check({31'h0, biphase_audio_out_pin}, 32'h0);
        check(32'(frames > 250), 32'h1);
        summarize();
    end
endmodule // biphase_mark_audio_output_bench
